/* hw/capw_pkg.sv */
package capw_pkg;

    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_MODE = 8'h04;
    localparam logic [7:0] OFF_PWMCFG = 8'h08;
    localparam logic [7:0] OFF_CNT_LO = 8'h0C;
    localparam logic [7:0] OFF_CNT_HI = 8'h10;
    localparam logic [7:0] OFF_MMODE_BASE = 8'h20;
    localparam logic [7:0] OFF_CPL_BASE = 8'h30;
    localparam logic [7:0] OFF_CPH_BASE = 8'h40;
    localparam logic [7:0] MOD_STRIDE = 8'h04;

    // ----------------------------------------
    // field positions and reset values
    // ----------------------------------------
    localparam int CTRL_CF = 7;
    localparam int CTRL_CR = 6;
    localparam int MD_IDLE = 7;
    localparam int MD_WATCHDOG_ENABLE = 6;
    localparam int MD_WATCHDOG_LOCK = 5;
    localparam int MD_CPS_LSB = 1;
    localparam int MD_ECF = 0;
    localparam int PC_RELOAD_VIEW_SELECT = 7;
    localparam int PC_ECOV = 6;
    localparam int PC_CYCLE_OVERFLOW_FLAG = 5;
    localparam int WDT_MOD = 2;
    localparam logic [2:0] CPS_RESET = 3'h0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ONES = 8'hFF;
    localparam logic [15:0] WORD_ONES = 16'hFFFF;

    // ----------------------------------------
    // counter clock and cycle lengths
    // ----------------------------------------
    localparam logic [3:0] DIV_SLOW = 4'd12;
    localparam logic [3:0] DIV_FAST = 4'd4;
    localparam logic [3:0] DIV_NONE = 4'd1;
    localparam logic [15:0] MASK_8 = 16'h00FF;
    localparam logic [15:0] MASK_9 = 16'h01FF;
    localparam logic [15:0] MASK_10 = 16'h03FF;
    localparam logic [15:0] MASK_11 = 16'h07FF;

    typedef enum logic [1:0] {CL_8, CL_9, CL_10, CL_11} capw_cycle_length_select_e;

    typedef struct packed {
        logic wide_pwm_select;
        logic comparator_enable;
        logic cap_pos;
        logic cap_neg;
        logic match_flag_enable;
        logic toggle;
        logic pwm_select;
        logic module_irq_enable;
    } capw_mode_s;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } capw_apb_req_s;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } capw_apb_rsp_s;

endpackage : capw_pkg

/* hw/capw_top.sv */
// Notes on behaviour
// - 8-bit PWM: output high on low-byte compare match, low on low-byte overflow
// - 8-bit PWM: on low-byte wrap, compare high byte copies into compare low byte
// - 8-bit PWM selected by comparator enable, pwm select, wide select clear and cycle length 00
// - match flag enable set: each comparator match sets the module event flag
// - 8-bit PWM: cycle overflow flag set on each low-byte overflow, every 256
// - compare low write clears comparator enable, high write sets it
// - 8-bit duty is (256 - high byte)/256; zero gives constant high
// - any PWM mode: comparator enable clear holds output low
// - reload view select routes compare addresses to the auto-reload register
// - N-bit PWM: high on N-bit compare match, low on overflow into bit N
// - N-bit overflow sets cycle overflow flag and loads auto-reload into compare
// - cycle length field picks N of 9, 10 or 11
// - 16-bit PWM: high on full match, low on counter overflow
// - 16-bit PWM: counter overflow flag marks falling edge; software paces writes
// - watchdog enable makes module 2 a watchdog on the counter high byte
// - after reset watchdog on, counter clock divide by 12, bytes zero
// - watchdog on: counter runs, counter writes, clock, idle and module 2 mode frozen
// - watchdog on: run bit writes do not stop counter; reads software value
// - update byte write loads counter high byte plus offset byte
// - watchdog reset when low byte overflows while update byte equals high byte
// - watchdog on: writing 1 to module 2 event flag forces watchdog reset
// - enable or lock turns watchdog on; lock holds until system reset
// - counter overflow flag set on 16-bit wrap, held until software clears
//
// The address map and the APB register port were decided locally.
`timescale 1ns/10ps
module capw_top #(
    parameter int NUM_MOD = 3
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic idle_mode,
    input wire capw_pkg::capw_apb_req_s apb_req,
    output capw_pkg::capw_apb_rsp_s apb_rsp,
    output logic [NUM_MOD-1:0] module_output_pin,
    output logic watchdog_reset
);
    import capw_pkg::*;

    // ----------------------------------------
    // elaboration check
    // ----------------------------------------
    if (NUM_MOD <= WDT_MOD || NUM_MOD > 4)
    begin : g_bad
        $error("NUM_MOD must be 3 or 4");
    end

    function automatic logic [7:0] slot(input logic [7:0] base, input int idx);
        slot = base + 8'(idx) * MOD_STRIDE;
    endfunction : slot

    function automatic logic [15:0] len_mask(input logic [1:0] cl);
        unique case (capw_cycle_length_select_e'(cl))
            CL_8: len_mask = MASK_8;
            CL_9: len_mask = MASK_9;
            CL_10: len_mask = MASK_10;
            CL_11: len_mask = MASK_11;
        endcase
    endfunction : len_mask

    function automatic logic [3:0] cps_div(input logic [2:0] cps);
        cps_div = (cps == CPS_RESET) ? DIV_SLOW : ((cps == 3'h1) ? DIV_FAST : DIV_NONE);
    endfunction : cps_div

    // ----------------------------------------
    // state
    // ----------------------------------------
    capw_apb_rsp_s rsp_ff;
    logic [15:0] cnt_ff;
    logic [3:0] presc_ff;
    logic cf_ff, cr_ff, idle_sus_ff, watchdog_enable_ff, watchdog_lock_ff, ecf_ff;
    logic [2:0] cps_ff;
    logic reload_view_select_ff, ecov_ff, cycle_overflow_flag_ff;
    logic [1:0] cycle_length_select_ff;
    capw_mode_s mode_ff [NUM_MOD];
    logic [7:0] cpl_ff [NUM_MOD];
    logic [7:0] cph_ff [NUM_MOD];
    logic [10:0] arr_ff [NUM_MOD];
    logic [NUM_MOD-1:0] ccf_ff, out_ff;
    logic wdt_rst_ff;

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    wire logic [7:0] addr = apb_req.paddr;
    wire logic [7:0] wd = apb_req.pwdata[7:0];
    wire logic access = apb_req.psel & apb_req.penable;
    wire logic fire = access & rsp_ff.pready;
    wire logic wr_fire = fire & apb_req.pwrite;
    wire logic hit_ctrl = addr == OFF_CTRL;
    wire logic hit_mode = addr == OFF_MODE;
    wire logic hit_pcfg = addr == OFF_PWMCFG;
    wire logic hit_clo = addr == OFF_CNT_LO;
    wire logic hit_chi = addr == OFF_CNT_HI;
    wire logic wdt_en = watchdog_enable_ff | watchdog_lock_ff;
    wire logic wr_ctrl = wr_fire & hit_ctrl;
    wire logic wr_mode = wr_fire & hit_mode;
    wire logic wr_pcfg = wr_fire & hit_pcfg;
    wire logic wr_cnt_lo = wr_fire & hit_clo & ~wdt_en;
    wire logic wr_cnt_hi = wr_fire & hit_chi & ~wdt_en;
    logic [NUM_MOD-1:0] hit_mm, hit_cl, hit_ch;
    logic [NUM_MOD-1:0] wr_mm, wr_cl, wr_ch, wr_al, wr_ah;
    always_comb
    begin
        for (int i = 0; i < NUM_MOD; i++)
        begin
            hit_mm[i] = addr == slot(OFF_MMODE_BASE, i);
            hit_cl[i] = addr == slot(OFF_CPL_BASE, i);
            hit_ch[i] = addr == slot(OFF_CPH_BASE, i);
            // module 2 mode frozen under watchdog
            wr_mm[i] = wr_fire & hit_mm[i] & ~(i == WDT_MOD && wdt_en);
            wr_cl[i] = wr_fire & hit_cl[i] & ~reload_view_select_ff;
            wr_ch[i] = wr_fire & hit_ch[i] & ~reload_view_select_ff;
            wr_al[i] = wr_fire & hit_cl[i] & reload_view_select_ff;
            wr_ah[i] = wr_fire & hit_ch[i] & reload_view_select_ff;
        end
    end
    wire logic mapped = hit_ctrl | hit_mode | hit_pcfg | hit_clo | hit_chi
                        | (|hit_mm) | (|hit_cl) | (|hit_ch);

    // ----------------------------------------
    // counter timebase
    // ----------------------------------------
    wire logic run = (cr_ff | wdt_en) & ~(idle_sus_ff & idle_mode);
    wire logic [3:0] div = cps_div(cps_ff);
    wire logic tick = run & (presc_ff == div - 4'd1);
    wire logic [15:0] cnt_inc = cnt_ff + 16'd1;
    wire logic [15:0] nmask = len_mask(cycle_length_select_ff);
    wire logic lo_ovf = tick & (cnt_ff[7:0] == BYTE_ONES);
    wire logic full_ovf = tick & (cnt_ff == WORD_ONES);
    wire logic n_ovf = tick & ((cnt_ff & nmask) == nmask);
    wire logic pwm8 = cycle_length_select_ff == 2'(CL_8);
    wire logic [7:0] upd_val = cnt_ff[15:8] + cpl_ff[WDT_MOD];
    wire logic wdt_hit = cph_ff[WDT_MOD] == cnt_ff[15:8];

    // ----------------------------------------
    // per-module compare and output
    // ----------------------------------------
    logic [NUM_MOD-1:0] is_pwm, wide, match, fall, reload;
    logic [15:0] cp_now [NUM_MOD];
    logic [15:0] rl_word [NUM_MOD];
    logic [15:0] cmp_ref [NUM_MOD];
    always_comb
    begin
        for (int i = 0; i < NUM_MOD; i++)
        begin
            // watchdog forces module 2 into software timer
            is_pwm[i] = mode_ff[i].pwm_select & ~(i == WDT_MOD && wdt_en);
            wide[i] = is_pwm[i] & mode_ff[i].wide_pwm_select;
            cp_now[i] = {cph_ff[i], cpl_ff[i]};
            // 8-bit keeps high byte and copies it down
            rl_word[i] = pwm8 ? {cph_ff[i], cph_ff[i]} : {5'h00, arr_ff[i]};
            reload[i] = is_pwm[i] & ~wide[i] & n_ovf;
            // the reloaded value is what the new count meets
            cmp_ref[i] = reload[i] ? rl_word[i] : cp_now[i];
            if (wide[i] || !is_pwm[i])
            begin
                match[i] = tick & (cnt_inc == cp_now[i]);
                fall[i] = full_ovf;
            end
            else
            begin
                match[i] = tick & ((cnt_inc & nmask) == (cmp_ref[i] & nmask));
                fall[i] = n_ovf;
            end
        end
    end

    // ----------------------------------------
    // read data
    // ----------------------------------------
    logic [7:0] rd_byte;
    always_comb
    begin
        rd_byte = BYTE_ZERO;
        if (hit_ctrl)
            rd_byte = {cf_ff, cr_ff, 3'h0, ccf_ff[2:0]};
        if (hit_mode)
            rd_byte = {idle_sus_ff, watchdog_enable_ff, watchdog_lock_ff, 1'b0, cps_ff, ecf_ff};
        if (hit_pcfg)
            rd_byte = {reload_view_select_ff, ecov_ff, cycle_overflow_flag_ff, 3'h0, cycle_length_select_ff};
        if (hit_clo)
            rd_byte = cnt_ff[7:0];
        if (hit_chi)
            rd_byte = cnt_ff[15:8];
        for (int i = 0; i < NUM_MOD; i++)
        begin
            if (hit_mm[i])
                rd_byte = mode_ff[i];
            if (hit_cl[i])
                rd_byte = reload_view_select_ff ? arr_ff[i][7:0] : cpl_ff[i];
            if (hit_ch[i])
                rd_byte = reload_view_select_ff ? {5'h00, arr_ff[i][10:8]} : cph_ff[i];
        end
    end

    // ----------------------------------------
    // bus slave: one wait state, then ready
    // ----------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            rsp_ff <= '0;
        else
        begin
            rsp_ff.pready <= access & ~rsp_ff.pready;
            rsp_ff.pslverr <= access & ~rsp_ff.pready & ~mapped;
            rsp_ff.prdata <= (access & ~rsp_ff.pready) ? {24'h000000, rd_byte} : '0;
        end
    end

    // ----------------------------------------
    // counter, control and mode
    // ----------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            presc_ff <= '0;
            cnt_ff <= '0;
            cf_ff <= 1'b0;
            cr_ff <= 1'b0;
            idle_sus_ff <= 1'b0;
            watchdog_enable_ff <= 1'b1;
            watchdog_lock_ff <= 1'b0;
            cps_ff <= CPS_RESET;
            ecf_ff <= 1'b0;
            reload_view_select_ff <= 1'b0;
            ecov_ff <= 1'b0;
            cycle_overflow_flag_ff <= 1'b0;
            cycle_length_select_ff <= '0;
            wdt_rst_ff <= 1'b0;
        end
        else
        begin
            presc_ff <= (!run || tick) ? 4'h0 : presc_ff + 4'h1;
            if (wr_cnt_lo)
                cnt_ff[7:0] <= wd;
            else if (wr_cnt_hi)
                cnt_ff[15:8] <= wd;
            else if (tick)
                cnt_ff <= cnt_inc;
            // set wins over a clearing write
            cf_ff <= full_ovf | (cf_ff & ~(wr_ctrl & ~wd[CTRL_CF]));
            if (wr_ctrl)
                cr_ff <= wd[CTRL_CR];
            if (wr_mode)
            begin
                watchdog_enable_ff <= wd[MD_WATCHDOG_ENABLE];
                watchdog_lock_ff <= watchdog_lock_ff | wd[MD_WATCHDOG_LOCK];
                ecf_ff <= wd[MD_ECF];
                if (!wdt_en)
                begin
                    idle_sus_ff <= wd[MD_IDLE];
                    cps_ff <= wd[MD_CPS_LSB +: 3];
                end
            end
            if (wr_pcfg)
            begin
                reload_view_select_ff <= wd[PC_RELOAD_VIEW_SELECT];
                ecov_ff <= wd[PC_ECOV];
                cycle_length_select_ff <= wd[1:0];
            end
            cycle_overflow_flag_ff <= n_ovf | (cycle_overflow_flag_ff & ~(wr_pcfg & ~wd[PC_CYCLE_OVERFLOW_FLAG]));
            wdt_rst_ff <= wdt_en & ((lo_ovf & wdt_hit)
                                    | (wr_ctrl & wd[WDT_MOD]));
        end
    end

    always_ff @(posedge ref_clk)
    begin
        for (int i = 0; i < NUM_MOD; i++)
        begin
            if (rst)
            begin
                mode_ff[i] <= '0;
                cpl_ff[i] <= BYTE_ZERO;
                cph_ff[i] <= BYTE_ZERO;
                arr_ff[i] <= '0;
                ccf_ff[i] <= 1'b0;
                out_ff[i] <= 1'b0;
            end
            else
            begin
                if (wr_mm[i])
                    mode_ff[i] <= wd;
                else if (wr_cl[i])
                    mode_ff[i].comparator_enable <= 1'b0;
                else if (wr_ch[i] && !(i == WDT_MOD && wdt_en))
                    mode_ff[i].comparator_enable <= 1'b1;
                // software write wins over a same-cycle reload
                if (wr_cl[i])
                    cpl_ff[i] <= wd;
                else if (reload[i])
                    cpl_ff[i] <= rl_word[i][7:0];
                if (wr_ch[i])
                    cph_ff[i] <= (i == WDT_MOD && wdt_en) ? upd_val : wd;
                else if (reload[i])
                    cph_ff[i] <= rl_word[i][15:8];
                if (wr_al[i])
                    arr_ff[i][7:0] <= wd;
                if (wr_ah[i])
                    arr_ff[i][10:8] <= wd[2:0];
                ccf_ff[i] <= (match[i] & mode_ff[i].comparator_enable
                              & mode_ff[i].match_flag_enable)
                             | (ccf_ff[i] & ~(wr_ctrl & ~wd[i]));
                if (!is_pwm[i] || !mode_ff[i].comparator_enable)
                    out_ff[i] <= 1'b0;
                else if (match[i])
                    out_ff[i] <= 1'b1;
                else if (fall[i])
                    out_ff[i] <= 1'b0;
            end
        end
    end

    assign apb_rsp = rsp_ff;
    assign module_output_pin = out_ff;
    assign watchdog_reset = wdt_rst_ff;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    wire logic m0_on = is_pwm[0] & mode_ff[0].comparator_enable;

    AST_PWM_OFF_LOW: assert property (is_pwm[0] & ~mode_ff[0].comparator_enable
        |=> ~module_output_pin[0]) else $error("pwm output high with comparator off");
    AST_PWM8_RELOAD: assert property (reload[0] & pwm8 & ~wr_cl[0]
        |=> cpl_ff[0] == $past(cph_ff[0])) else $error("8-bit reload missed");
    AST_PWM8_FALL: assert property (m0_on & ~wide[0] & pwm8 & lo_ovf
        & (cph_ff[0] != BYTE_ZERO) & ~wr_mm[0] |=> ~module_output_pin[0])
        else $error("8-bit output not low after overflow");
    AST_CYCLE_OVERFLOW_FLAG_SET: assert property (n_ovf |=> cycle_overflow_flag_ff) else $error("cycle flag not set");
    AST_ECOM_CLR: assert property (wr_cl[0] & ~wr_mm[0]
        |=> ~mode_ff[0].comparator_enable) else $error("low write kept comparator on");
    AST_MATCH_FLAG: assert property (match[0] & mode_ff[0].comparator_enable
        & mode_ff[0].match_flag_enable |=> ccf_ff[0]) else $error("event flag missed");
    AST_WIDE_HIGH: assert property (m0_on & wide[0] & match[0] & ~wr_mm[0]
        |=> module_output_pin[0] ##1 (module_output_pin[0] | $past(fall[0]) | $past(rst)))
        else $error("16-bit output not high on match");
    AST_WDT_UPDATE: assert property (wdt_en & wr_ch[WDT_MOD]
        |=> cph_ff[WDT_MOD] == $past(upd_val)) else $error("watchdog update value wrong");
    AST_WDT_RUN: assert property (wdt_en & tick
        |=> cnt_ff == $past(cnt_inc)) else $error("counter not forced running");
    AST_WDT_FIRE: assert property (wdt_en & lo_ovf & wdt_hit
        |=> watchdog_reset ##1 ~watchdog_reset[*1]) else $error("watchdog reset missed");
    AST_WDT_LOCK: assert property (watchdog_lock_ff |=> wdt_en [*4])
        else $error("locked watchdog turned off");
    AST_CF_HOLD: assert property (cf_ff & ~wr_ctrl |=> cf_ff)
        else $error("overflow flag cleared by hardware");
    AST_DIV12: assert property (tick & (cps_ff == CPS_RESET) & run
        |=> ~tick [*8]) else $error("counter clock faster than divide by 12");

    COV_PWM8_CYCLE: cover property (m0_on & pwm8 & match[0] ##[1:300] fall[0]);
    COV_PWM16_HIGH: cover property (m0_on & wide[0] & match[0]);
    COV_WDT_TIMEOUT: cover property (wdt_en & lo_ovf & wdt_hit);
    COV_NBIT_RELOAD: cover property (reload[1] & ~pwm8);

endmodule : capw_top

/* tb/capw_tb.sv */
`timescale 1ns/10ps
module testbench;
    import capw_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic idle_mode = 1'b0;
    capw_apb_req_s req = '0;
    capw_apb_rsp_s rsp;
    logic [2:0] pin;
    logic wd_rst;
    logic [7:0] q;
    logic e;
    int c;
    int n_fail = 0;
    int tests_run = 0;

    always #10 ref_clk = ~ref_clk;

    capw_top #(.NUM_MOD(3)) i_capw_top (
        .ref_clk(ref_clk),
        .rst(rst),
        .idle_mode(idle_mode),
        .apb_req(req),
        .apb_rsp(rsp),
        .module_output_pin(pin),
        .watchdog_reset(wd_rst)
    );

    // ----------------------------------------
    // bus and compare helpers
    // ----------------------------------------
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge ref_clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h000000, d}};
        @(posedge ref_clk);
        req.penable <= 1'b1;
        // sampled at the edge: reads see the pre-edge value of pready
        do
        begin
            @(posedge ref_clk);
            k++;
        end
        while (rsp.pready !== 1'b1 && k < 20);
        if (k >= 20)
            chk("pready", 16'h0001, 16'h0000);
        q = rsp.prdata[7:0];
        e = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        chk(nm, {8'h00, exp}, {8'h00, q});
    endtask : rd

    task automatic do_reset();
        rst <= 1'b1;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
    endtask : do_reset

    // counts cycles until the reset request, n if it never came
    task automatic wait_wd(input int n, output int k);
        for (k = 0; k < n; k++)
        begin
            @(posedge ref_clk);
            if (wd_rst === 1'b1)
                break;
        end
    endtask : wait_wd

    task automatic high_cycles(input int n, output int k);
        k = 0;
        repeat (n)
        begin
            @(posedge ref_clk);
            if (pin[0] === 1'b1)
                k++;
        end
    endtask : high_cycles

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset_wd();
        rd("mode", OFF_MODE, 8'h40);
        rd("control", OFF_CTRL, 8'h00);
        apb(1'b0, 8'hFC, 8'h00);
        chk("unmapped err", 16'h0001, {15'h0000, e});
        wait_wd(3200, c);
        chk("default timeout", 16'h0001, {15'h0000, 1'(c > 2950 && c < 3090)});
        do_reset();
        wr(OFF_CTRL, 8'h04);
        wait_wd(10, c);
        chk("forced reset", 16'h0001, {15'h0000, 1'(c < 10)});
        do_reset();
    endtask : t_reset_wd

    task automatic t_pwm8();
        logic [7:0] d [3] = '{8'h00, 8'h80, 8'hFF};
        // watchdog off first: clock select is frozen while it runs
        wr(OFF_MODE, 8'h00);
        wr(OFF_MODE, 8'h04);
        wr(OFF_CTRL, 8'h40);
        wr(OFF_PWMCFG, 8'h00);
        wr(OFF_MMODE_BASE, 8'h4A);
        foreach (d[i])
        begin
            wr(OFF_CPL_BASE, d[i]);
            wr(OFF_CPH_BASE, d[i]);
            repeat (600) @(posedge ref_clk);
            high_cycles(256, c);
            chk("duty8", 16'(256 - int'(d[i])), c[15:0]);
        end
        apb(1'b0, OFF_CTRL, 8'h00);
        chk("event flag", 16'h0001, {15'h0000, q[0]});
        apb(1'b0, OFF_PWMCFG, 8'h00);
        chk("cycle ovf", 16'h0001, {15'h0000, q[5]});
        wr(OFF_CPL_BASE, 8'h40);
        rd("mode0", OFF_MMODE_BASE, 8'h0A);
        high_cycles(512, c);
        chk("duty off", 16'h0000, c[15:0]);
    endtask : t_pwm8

    task automatic t_pwm_select();
        int p;
        logic [10:0] r;
        for (int n = 9; n <= 11; n++)
        begin
            p = 1 << n;
            r = 11'(p / 4);
            wr(OFF_PWMCFG, 8'h80 | 8'(n - 8));
            wr(OFF_CPL_BASE, r[7:0]);
            wr(OFF_CPH_BASE, {5'h00, r[10:8]});
            wr(OFF_MMODE_BASE, 8'h4A);
            repeat (2 * p + 20) @(posedge ref_clk);
            high_cycles(p, c);
            chk("duty n", 16'(p - p / 4), c[15:0]);
        end
    endtask : t_pwm_select

    task automatic t_pwm16();
        wr(OFF_PWMCFG, 8'h00);
        wr(OFF_MMODE_BASE, 8'hC2);
        wr(OFF_CTRL, 8'h40);
        wr(OFF_CPL_BASE, 8'h80);
        wr(OFF_CPH_BASE, 8'hFF);
        // low byte first so it cannot carry into the high byte in between
        wr(OFF_CNT_LO, 8'h00);
        wr(OFF_CNT_HI, 8'hFE);
        high_cycles(600, c);
        chk("duty16", 16'd128, c[15:0]);
        apb(1'b0, OFF_CTRL, 8'h00);
        chk("counter ovf", 16'h0001, {15'h0000, q[7]});
    endtask : t_pwm16

    task automatic t_wd_offset();
        wr(OFF_MODE, 8'h04);
        wr(OFF_CNT_LO, 8'h00);
        wr(OFF_CNT_HI, 8'h10);
        wr(OFF_CPL_BASE + 8'h08, 8'h02);
        wr(OFF_MODE, 8'h44);
        wr(OFF_CNT_HI, 8'h55);
        rd("count high", OFF_CNT_HI, 8'h10);
        wr(OFF_MODE, 8'h40);
        rd("mode frozen", OFF_MODE, 8'h44);
        wr(OFF_CTRL, 8'h00);
        rd("run bit", OFF_CTRL, 8'h00);
        wr(OFF_CPH_BASE + 8'h08, 8'hAA);
        rd("update byte", OFF_CPH_BASE + 8'h08, 8'h12);
        wait_wd(600, c);
        chk("no early reset", 16'd600, c[15:0]);
        wait_wd(300, c);
        chk("offset reset", 16'h0001, {15'h0000, 1'(c < 300)});
        do_reset();
        // lock keeps the watchdog on even after enable is cleared
        wr(OFF_MODE, 8'h20);
        wr(OFF_MODE, 8'h00);
        wr(OFF_CTRL, 8'h04);
        wait_wd(10, c);
        chk("locked", 16'h0001, {15'h0000, 1'(c < 10)});
    endtask : t_wd_offset

    // ----------------------------------------
    // verdict and main sequence
    // ----------------------------------------
    task automatic finish_test();
        if (n_fail == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test

    initial
    begin
        do_reset();
        t_reset_wd();
        t_pwm8();
        t_pwm_select();
        t_pwm16();
        t_wd_offset();
        finish_test();
    end

    // whole sequence needs about 20k cycles
    initial
    begin
        repeat (60000) @(posedge ref_clk);
        n_fail++;
        finish_test();
    end
endmodule : testbench
